// ### oldx_pkg.sv
package oldx_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PROC = 8'h04;
   localparam logic [7:0] REG_INIT = 8'h08;
   localparam logic [7:0] REG_CHAN = 8'h0C;
   localparam logic [7:0] REG_TIME = 8'h10;
   localparam logic [7:0] REG_KEEP = 8'h14;
   localparam logic [7:0] REG_STAT = 8'h18;
   localparam logic [7:0] REG_ERRH = 8'h1C;
   localparam logic [7:0] REG_ERRL = 8'h20;
   // ****************************************
   // reset values and limits
   // ****************************************
   localparam logic [5:0] MON_RST = 6'h00;
   localparam logic [5:0] MON_MAX = 6'h32;
   localparam logic [6:0] PER_RST = 7'h01;
   localparam logic [6:0] PER_MIN = 7'h01;
   localparam logic [6:0] PER_MAX = 7'h64;
   localparam logic [7:0] COMM_TO_RST = 8'h00;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int MS_US = 1000;
   localparam int FULL_US = 500;
   localparam int MS_CYC = MS_US * CLK_MHZ;
   localparam int FULL_CYC = FULL_US * CLK_MHZ;
   localparam logic [16:0] S_MS = 17'h003E8;
   localparam logic [7:0] QTR_MS = 8'hFA;
   localparam logic [2:0] N_PULSE = 3'h4;
   localparam logic [7:0] BLINK_MS = 8'hFA;
   // ****************************************
   // error code bits, high pole / low pole
   // ****************************************
   localparam int EH_TO_LS = 0;
   localparam int EH_TO_SUP = 1;
   localparam int EH_TO_GND = 2;
   localparam int E_OPEN = 3;
   localparam int EL_TO_SUP = 0;
   localparam int EL_TO_GND = 1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FULL = 2'b01,
      ST_RED = 2'b10
   } oldx_state_t;
endpackage

// ### oldx_top.sv
`timescale 1ns/1ps
`default_nettype none
module oldx_top
   import oldx_pkg::*;
#(
   parameter int N_CH = 8,
   parameter int MS_CYCLES = MS_CYC,
   parameter int FULL_CYCLES = FULL_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic critical_fail,
   input wire logic watchdog_trip,
   input wire logic internal_fault,
   input wire logic [3:0] internal_code,
   input wire logic overload_all,
   input wire logic [N_CH-1:0] overload,
   input wire logic [N_CH-1:0] hs_readback,
   input wire logic [N_CH-1:0] ls_readback,
   input wire logic [N_CH-1:0] load_current,
   input wire logic [N_CH-1:0] load_overcurrent,
   output logic [N_CH-1:0] hs_drive,
   output logic [N_CH-1:0] ls_drive,
   output logic [N_CH-1:0] reduced_voltage,
   output logic [N_CH-1:0] output_led,
   output logic fault_led,
   output logic cycle_stretch
);
   // ****************************************
   // registers
   // ****************************************
   logic line_check_enable_ff;
   logic lamp_mode_ff;
   logic [7:0] comm_to_ff;
   logic [N_CH-1:0] proc_ff;
   logic [N_CH-1:0] init_ff;
   logic [N_CH-1:0] channel_line_check_enable_ff;
   logic [N_CH-1:0] two_pole_ff;
   logic [5:0] mon_ff;
   logic [6:0] per_ff;
   logic [3:0] int_code_ff;
   logic [4*N_CH-1:0] err_hs_ff;
   logic [4*N_CH-1:0] err_ls_ff;
   logic [4*N_CH-1:0] pend_hs_ff;
   logic [4*N_CH-1:0] pend_ls_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic wr;
   logic setup;
   logic [31:0] wd;
   logic [5:0] wmon;
   logic [6:0] wper;

   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign wd = pwdata;
   assign pready = 1'b1;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff;

   // out-of-range settings saturate instead of faulting the bus
   always_comb begin
      wmon = wd[5:0];
      if (wd[5:0] > MON_MAX) begin
         wmon = MON_MAX;
      end
      wper = wd[22:16];
      if (wd[22:16] < PER_MIN) begin
         wper = PER_MIN;
      end else if (wd[22:16] > PER_MAX) begin
         wper = PER_MAX;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_check_enable_ff <= 1'b0;
         lamp_mode_ff <= 1'b0;
         comm_to_ff <= COMM_TO_RST;
         proc_ff <= '0;
         init_ff <= '0;
         channel_line_check_enable_ff <= '0;
         two_pole_ff <= '0;
         mon_ff <= MON_RST;
         per_ff <= PER_RST;
      end else if (ce && wr) begin
         case (paddr)
            REG_CTRL: begin
               line_check_enable_ff <= wd[0];
               lamp_mode_ff <= wd[1];
               comm_to_ff <= wd[15:8];
            end
            REG_PROC: begin
               proc_ff <= wd[N_CH-1:0];
            end
            REG_INIT: begin
               init_ff <= wd[N_CH-1:0];
            end
            REG_CHAN: begin
               channel_line_check_enable_ff <= wd[N_CH-1:0];
               two_pole_ff <= wd[N_CH+7:8];
            end
            REG_TIME: begin
               mon_ff <= wmon;
               per_ff <= wper;
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // millisecond tick and communication watch
   // ****************************************
   logic [31:0] ms_cnt_ff;
   logic tick;
   logic [7:0] comm_cnt_ff;
   logic comm_lost_ff;
   logic keep;

   assign tick = (ms_cnt_ff == 32'(MS_CYCLES - 1));
   assign keep = wr && (paddr == REG_KEEP);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt_ff <= '0;
      end else if (ce) begin
         ms_cnt_ff <= tick ? '0 : ms_cnt_ff + 32'h00000001;
      end
   end

   // a zero timeout disables the watch; any keep-alive write revives it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comm_cnt_ff <= '0;
         comm_lost_ff <= 1'b0;
      end else if (ce) begin
         // expiry wins over a keep-alive in the same cycle
         if (comm_to_ff == 8'h00) begin
            comm_cnt_ff <= '0;
            comm_lost_ff <= 1'b0;
         end else if (tick && !comm_lost_ff && (comm_cnt_ff + 8'h01 >= comm_to_ff)) begin
            comm_cnt_ff <= comm_cnt_ff + 8'h01;
            comm_lost_ff <= 1'b1;
         end else if (keep) begin
            comm_cnt_ff <= '0;
            comm_lost_ff <= 1'b0;
         end else if (tick && !comm_lost_ff) begin
            comm_cnt_ff <= comm_cnt_ff + 8'h01;
         end
      end
   end

   // ****************************************
   // test period and pulse schedule
   // ****************************************
   oldx_state_t st_ff;
   logic [16:0] per_ms_ff;
   logic [16:0] per_len;
   logic per_end;
   logic [7:0] q_ms_ff;
   logic [2:0] pulses_ff;
   logic [31:0] full_cnt_ff;
   logic [5:0] red_ms_ff;
   logic start;
   logic any_diag;
   logic [N_CH-1:0] diag;

   assign diag = {N_CH{line_check_enable_ff}} & channel_line_check_enable_ff & two_pole_ff;
   assign any_diag = |diag;
   assign per_len = 17'(per_ff * S_MS);
   // shortening the period mid-run must not skip the period end
   assign per_end = tick && (per_ms_ff >= per_len - 17'h00001);
   // zero monitor time means no pulse at all
   assign start = tick && (q_ms_ff == 8'h00) && (pulses_ff < N_PULSE)
                  && (st_ff == ST_IDLE) && any_diag && (mon_ff != 6'h00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_ms_ff <= '0;
         q_ms_ff <= '0;
         pulses_ff <= '0;
      end else if (ce && tick) begin
         if (per_end) begin
            per_ms_ff <= '0;
            q_ms_ff <= '0;
            pulses_ff <= '0;
         end else begin
            per_ms_ff <= per_ms_ff + 17'h00001;
            q_ms_ff <= (q_ms_ff == QTR_MS - 8'h01) ? 8'h00 : q_ms_ff + 8'h01;
            if (q_ms_ff == 8'h00 && pulses_ff < N_PULSE) begin
               pulses_ff <= pulses_ff + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= ST_IDLE;
         full_cnt_ff <= '0;
         red_ms_ff <= '0;
      end else if (ce) begin
         case (st_ff)
            ST_IDLE: begin
               full_cnt_ff <= '0;
               red_ms_ff <= '0;
               if (start) begin
                  st_ff <= lamp_mode_ff ? ST_FULL : ST_RED;
               end
            end
            ST_FULL: begin
               full_cnt_ff <= full_cnt_ff + 32'h00000001;
               if (full_cnt_ff == 32'(FULL_CYCLES - 1)) begin
                  st_ff <= ST_RED;
               end
            end
            ST_RED: begin
               if (tick) begin
                  red_ms_ff <= red_ms_ff + 6'h01;
                  if (red_ms_ff + 6'h01 >= mon_ff) begin
                     st_ff <= ST_IDLE;
                  end
               end
            end
            default: begin
               st_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // per-channel diagnosis and output drive
   // ****************************************
   logic [4*N_CH-1:0] new_hs;
   logic [4*N_CH-1:0] new_ls;
   logic [N_CH-1:0] ch_bad;
   logic [N_CH-1:0] eff_val;
   logic [N_CH-1:0] out_val_ff;
   logic [N_CH-1:0] hs_ff;
   logic [N_CH-1:0] ls_ff;
   logic [N_CH-1:0] red_ff;
   logic all_off;
   logic samp_red;

   assign all_off = critical_fail | watchdog_trip | internal_fault | overload_all;
   assign eff_val = comm_lost_ff ? init_ff : proc_ff;
   assign samp_red = (st_ff == ST_RED) && tick;

   genvar g;
   generate
      for (g = 0; g < N_CH; g++) begin : g_ch
         logic on_pulse;
         logic idle_chk;
         assign on_pulse = diag[g] && (st_ff != ST_IDLE);
         // idle probe only when the channel sits switched off
         assign idle_chk = diag[g] && tick && (st_ff == ST_IDLE) && !out_val_ff[g];
         always_comb begin
            new_hs[4*g+3:4*g] = 4'h0;
            new_ls[4*g+3:4*g] = 4'h0;
            if (diag[g] && samp_red) begin
               new_hs[4*g+EH_TO_LS] = load_overcurrent[g];
               new_hs[4*g+EH_TO_GND] = !hs_readback[g];
               new_hs[4*g+E_OPEN] = hs_readback[g] && !load_current[g];
               new_ls[4*g+E_OPEN] = hs_readback[g] && !load_current[g];
               new_ls[4*g+EL_TO_SUP] = ls_readback[g];
            end
            if (idle_chk) begin
               new_hs[4*g+EH_TO_SUP] = hs_readback[g];
               new_ls[4*g+EL_TO_GND] = !ls_readback[g];
            end
         end
         assign ch_bad[g] = (|err_hs_ff[4*g+3:4*g]) | (|err_ls_ff[4*g+3:4*g]);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               out_val_ff[g] <= 1'b0;
            end else if (ce) begin
               if (on_pulse) begin
                  if (samp_red && new_hs[4*g+3:4*g] == 4'h0 && new_ls[4*g+3:4*g] == 4'h0) begin
                     out_val_ff[g] <= eff_val[g];
                  end
               end else begin
                  out_val_ff[g] <= eff_val[g];
               end
            end
         end
         // safe state opens both switches; overload clears by itself
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               hs_ff[g] <= 1'b0;
               ls_ff[g] <= 1'b0;
               red_ff[g] <= 1'b0;
            end else if (ce) begin
               // faulty channel still takes the reduced probe, else its code never clears
               if (all_off || overload[g] || (ch_bad[g] && !(diag[g] && st_ff == ST_RED))) begin
                  hs_ff[g] <= 1'b0;
                  ls_ff[g] <= 1'b0;
                  red_ff[g] <= 1'b0;
               end else begin
                  hs_ff[g] <= on_pulse | out_val_ff[g];
                  ls_ff[g] <= on_pulse | out_val_ff[g];
                  red_ff[g] <= diag[g] && (st_ff == ST_RED);
               end
            end
         end
      end
   endgenerate

   assign hs_drive = hs_ff;
   assign ls_drive = ls_ff;
   assign reduced_voltage = red_ff;
   assign output_led = hs_ff & ls_ff;
   assign cycle_stretch = (st_ff != ST_IDLE);

   // ****************************************
   // error codes per pole
   // ****************************************
   // new faults always land, even in the closing cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_hs_ff <= '0;
         err_ls_ff <= '0;
         pend_hs_ff <= '0;
         pend_ls_ff <= '0;
      end else if (ce) begin
         if (per_end) begin
            err_hs_ff <= pend_hs_ff | new_hs;
            err_ls_ff <= pend_ls_ff | new_ls;
            pend_hs_ff <= '0;
            pend_ls_ff <= '0;
         end else begin
            err_hs_ff <= err_hs_ff | new_hs;
            err_ls_ff <= err_ls_ff | new_ls;
            pend_hs_ff <= pend_hs_ff | new_hs;
            pend_ls_ff <= pend_ls_ff | new_ls;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_code_ff <= 4'h0;
      end else if (ce && internal_fault) begin
         int_code_ff <= internal_code;
      end
   end

   // ****************************************
   // fault indicator
   // ****************************************
   logic any_fault;
   logic [7:0] blink_cnt_ff;
   logic blink_ff;

   assign any_fault = (|ch_bad) | internal_fault | critical_fail | watchdog_trip;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blink_cnt_ff <= '0;
         blink_ff <= 1'b0;
      end else if (ce) begin
         if (!any_fault) begin
            blink_cnt_ff <= '0;
            blink_ff <= 1'b0;
         end else if (tick) begin
            if (blink_cnt_ff == BLINK_MS - 8'h01) begin
               blink_cnt_ff <= '0;
               blink_ff <= ~blink_ff;
            end else begin
               blink_cnt_ff <= blink_cnt_ff + 8'h01;
            end
         end
      end
   end

   // led starts lit at the first fault, then toggles every 250 ms
   assign fault_led = any_fault & ~blink_ff;

   // ****************************************
   // read path
   // ****************************************
   logic [31:0] rd;
   logic hit;

   always_comb begin
      rd = 32'h00000000;
      hit = 1'b1;
      case (paddr)
         REG_CTRL: begin
            rd = {16'h0000, comm_to_ff, 6'h00, lamp_mode_ff, line_check_enable_ff};
         end
         REG_PROC: begin
            rd[N_CH-1:0] = proc_ff;
         end
         REG_INIT: begin
            rd[N_CH-1:0] = init_ff;
         end
         REG_CHAN: begin
            rd[N_CH-1:0] = channel_line_check_enable_ff;
            rd[N_CH+7:8] = two_pole_ff;
         end
         REG_TIME: begin
            rd[5:0] = mon_ff;
            rd[22:16] = per_ff;
         end
         REG_KEEP: begin
            rd = 32'h00000000;
         end
         REG_STAT: begin
            rd[N_CH-1:0] = output_led;
            rd[8] = comm_lost_ff;
            rd[9] = internal_fault;
            rd[10] = critical_fail | watchdog_trip;
            rd[11] = overload_all | (|overload);
            rd[12] = cycle_stretch;
            rd[19:16] = int_code_ff;
         end
         REG_ERRH: begin
            rd[4*N_CH-1:0] = err_hs_ff;
         end
         REG_ERRL: begin
            rd[4*N_CH-1:0] = err_ls_ff;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // data latched in setup so the access phase answers at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end else if (ce && setup) begin
         prdata_ff <= pwrite ? 32'h00000000 : rd;
         pslverr_ff <= ~hit;
      end
   end
endmodule
`default_nettype wire

// ### oldx_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module oldx_mon
   import oldx_pkg::*;
#(
   parameter int N_CH = 8,
   parameter int MS_CYCLES = 20,
   parameter int FULL_CYCLES = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic critical_fail,
   input wire logic watchdog_trip,
   input wire logic internal_fault,
   input wire logic overload_all,
   input wire logic [N_CH-1:0] overload,
   input wire logic [N_CH-1:0] hs_drive,
   input wire logic [N_CH-1:0] ls_drive,
   input wire logic [N_CH-1:0] reduced_voltage,
   input wire logic [N_CH-1:0] output_led,
   input wire logic cycle_stretch
);
   // ****************************************
   // pulse timing counters
   // ****************************************
   logic st_ff;
   logic seen_ff;
   logic [31:0] len_ff;
   logic [31:0] low_ff;
   logic [31:0] gap_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= 1'b0;
         seen_ff <= 1'b0;
      end else begin
         st_ff <= cycle_stretch;
         seen_ff <= seen_ff | (cycle_stretch & ~st_ff);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_ff <= '0;
      end else begin
         len_ff <= cycle_stretch ? len_ff + 1 : '0;
      end
   end
   // full-voltage part: stretch high while no channel is reduced yet
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_ff <= '0;
      end else if (!cycle_stretch) begin
         low_ff <= '0;
      end else if (reduced_voltage == '0) begin
         low_ff <= low_ff + 1;
      end
   end
   // gap is only judged as a multiple, since diagnosis may be switched on late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_ff <= '0;
      end else begin
         gap_ff <= (cycle_stretch && !st_ff) ? 32'h1 : gap_ff + 1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   crit_off_a: assert property ((critical_fail || watchdog_trip) [*2] |-> (hs_drive | ls_drive) == '0)
      else $error("output on during critical failure");
   intf_off_a: assert property (internal_fault [*2] |-> (hs_drive | ls_drive) == '0)
      else $error("output on during internal fault");
   led_match_a: assert property (output_led == (hs_drive & ls_drive))
      else $error("status indicator differs from output");
   ovl_off_a: assert property ((overload & $past(overload) & output_led) == '0)
      else $error("overloaded channel still on");
   allovl_off_a: assert property (overload_all [*2] |-> output_led == '0)
      else $error("output on during global overload");
   red_stretch_a: assert property ($rose(|reduced_voltage) |-> cycle_stretch)
      else $error("reduced voltage outside stretched cycle");
   mon_len_a: assert property (len_ff <= FULL_CYCLES + 51 * MS_CYCLES)
      else $error("test pulse longer than monitor limit");
   full_len_a: assert property ($rose(|reduced_voltage) |->
      (low_ff <= 2 || (low_ff >= FULL_CYCLES && low_ff <= FULL_CYCLES + 2)))
      else $error("full-voltage pulse length wrong");
   pulse_gap_a: assert property (cycle_stretch && !st_ff && seen_ff |->
      gap_ff % (QTR_MS * MS_CYCLES) == 0)
      else $error("test pulses not on quarter spacing");
   cover property ($rose(|reduced_voltage) && low_ff >= FULL_CYCLES);
   cover property ($rose(|reduced_voltage) && low_ff <= 2);
   cover property (critical_fail [*2]);
   cover property (overload_all [*2]);
endmodule
bind oldx_top oldx_mon #(.N_CH(N_CH), .MS_CYCLES(MS_CYCLES), .FULL_CYCLES(FULL_CYCLES)) oldx_mon_inst (
   .pclk, .presetn, .critical_fail, .watchdog_trip, .internal_fault, .overload_all, .overload,
   .hs_drive, .ls_drive, .reduced_voltage, .output_led, .cycle_stretch);
`default_nettype wire

// ### oldx_load.sv
`timescale 1ns/1ps
`default_nettype none
module oldx_load (
   input wire logic [7:0] hs_drive,
   input wire logic [7:0] ls_drive,
   input wire logic [5:0] flt,
   input wire logic [7:0] flt_ch,
   output logic [7:0] hs_readback,
   output logic [7:0] ls_readback,
   output logic [7:0] load_current,
   output logic [7:0] load_overcurrent
);
   // ****************************************
   // load with injectable wiring faults
   // ****************************************
   wire [7:0] hl = {8{flt[0]}} & flt_ch;
   wire [7:0] hsu = {8{flt[1]}} & flt_ch;
   wire [7:0] hgn = {8{flt[2]}} & flt_ch;
   wire [7:0] lsu = {8{flt[3]}} & flt_ch;
   wire [7:0] lgn = {8{flt[4]}} & flt_ch;
   wire [7:0] op = {8{flt[5]}} & flt_ch;
   assign hs_readback = (hs_drive | hsu) & ~hgn;
   // low pole pulled up while its switch is open
   assign ls_readback = (~ls_drive | lsu) & ~lgn;
   assign load_current = hs_drive & ls_drive & ~hgn & ~op;
   assign load_overcurrent = hs_drive & ls_drive & hl;
endmodule
`default_nettype wire

// ### test_output_line_diagnosis_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_output_line_diagnosis_sequencer;
   import oldx_pkg::*;
   localparam int MSC = 10;
   localparam logic [5:0] FV [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
   localparam logic [7:0] FA [6] = '{REG_ERRH, REG_ERRH, REG_ERRH, REG_ERRL, REG_ERRL, REG_ERRH};
   localparam logic [31:0] FM [6] = '{32'h1, 32'h2, 32'h4, 32'h1, 32'h2, 32'h8};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic critical_fail = 1'b0;
   logic watchdog_trip = 1'b0;
   logic internal_fault = 1'b0;
   logic [3:0] internal_code = 4'h0;
   logic overload_all = 1'b0;
   logic [7:0] overload = 8'h00;
   logic [7:0] hs_readback, ls_readback, load_current, load_overcurrent;
   logic [7:0] hs_drive, ls_drive, reduced_voltage, output_led;
   logic fault_led, cycle_stretch;
   logic [5:0] flt = 6'h00;
   logic [7:0] flt_ch = 8'h01;
   logic [7:0] rv_seen = 8'h00;
   logic [31:0] rdat;
   logic rerr;
   int bad_count = 0;
   int n_tests = 0;
   always #5 pclk = ~pclk;
   always @(posedge pclk) rv_seen <= rv_seen | reduced_voltage;
   oldx_top #(.MS_CYCLES(MSC), .FULL_CYCLES(5)) oldx_top_inst (
      .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .critical_fail, .watchdog_trip, .internal_fault, .internal_code, .overload_all, .overload,
      .hs_readback, .ls_readback, .load_current, .load_overcurrent, .hs_drive, .ls_drive,
      .reduced_voltage, .output_led, .fault_led, .cycle_stretch);
   oldx_load oldx_load_inst (.hs_drive, .ls_drive, .flt, .flt_ch, .hs_readback, .ls_readback,
      .load_current, .load_overcurrent);
   // ****************************************
   // bus and compare helpers
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s exp=%h got=%h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // polls until masked bits match or 8000 more reads pass; the watchdog bounds the total
   task automatic wait_bits(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
      int k;
      apb(1'b0, a, 32'h0);
      for (k = 0; k < 8000 && (rdat & m) !== want; k++) apb(1'b0, a, 32'h0);
   endtask
   task automatic t_regs;
      chk("fault_led_idle", 32'h0, fault_led);
      apb(1'b0, REG_TIME, 32'h0);
      chk("time_rst", 32'h0001_0000, rdat);
      apb(1'b1, REG_TIME, 32'h007F_003F);
      apb(1'b0, REG_TIME, 32'h0);
      chk("time_sat", 32'h0064_0032, rdat);
      apb(1'b1, REG_TIME, 32'h0);
      apb(1'b0, REG_TIME, 32'h0);
      chk("time_min", 32'h0001_0000, rdat);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped_err", 32'h1, rerr);
      chk("unmapped_data", 32'h0, rdat);
   endtask
   task automatic t_comm;
      apb(1'b1, REG_PROC, 32'hA5);
      apb(1'b1, REG_INIT, 32'h5A);
      apb(1'b1, REG_CTRL, 32'h0300);
      apb(1'b1, REG_KEEP, 32'h0);
      repeat (6 * MSC) @(posedge pclk);
      chk("comm_lost_init", 32'h5A, output_led);
      apb(1'b1, REG_KEEP, 32'h0);
      repeat (3) @(posedge pclk);
      chk("comm_back", 32'hA5, output_led);
      apb(1'b1, REG_CTRL, 32'h0);
      overload <= 8'h04;
      repeat (3) @(posedge pclk);
      chk("ovl_one", 32'hA1, output_led);
      overload <= 8'h00;
      repeat (3) @(posedge pclk);
      chk("ovl_one_back", 32'hA5, output_led);
      overload_all <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("ovl_all", 32'h0, output_led);
      overload_all <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("ovl_all_back", 32'hA5, output_led);
   endtask
   task automatic t_diag;
      apb(1'b1, REG_PROC, 32'h02);
      apb(1'b1, REG_CHAN, 32'h070B);
      apb(1'b1, REG_TIME, 32'h0001_0002);
      rv_seen <= 8'h00;
      for (int i = 0; i < 6; i++) begin
         if (i == 5) apb(1'b1, REG_PROC, 32'h03);
         apb(1'b1, REG_CTRL, {30'h0, i[0], 1'b1});
         flt <= FV[i];
         wait_bits(FA[i], FM[i], FM[i]);
         chk("line_fault_code", FM[i], rdat & FM[i]);
      end
      while (cycle_stretch) @(posedge pclk);
      repeat (3) @(posedge pclk);
      chk("faulty_ch_off", 32'h2, output_led[1:0]);
      apb(1'b1, REG_PROC, 32'h02);
      flt <= 6'h00;
      wait_bits(REG_ERRH, 32'hFFFF_FFFF, 32'h0);
      chk("errh_cleared", 32'h0, rdat);
      wait_bits(REG_ERRL, 32'hFFFF_FFFF, 32'h0);
      chk("errl_cleared", 32'h0, rdat);
      apb(1'b1, REG_PROC, 32'h03);
      repeat (3) @(posedge pclk);
      chk("ch_released", 32'h3, output_led[1:0]);
      chk("diag_channels", 32'h03, rv_seen);
      apb(1'b1, REG_CTRL, 32'h0);
   endtask
   task automatic t_fault;
      critical_fail <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("crit_off", 32'h0, output_led);
      chk("crit_led", 32'h1, fault_led);
      repeat (252 * MSC) @(posedge pclk);
      chk("crit_led_blink", 32'h0, fault_led);
      critical_fail <= 1'b0;
      watchdog_trip <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("wdog_off", 32'h0, output_led);
      watchdog_trip <= 1'b0;
      internal_code <= 4'h9;
      internal_fault <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("intf_off", 32'h0, output_led);
      apb(1'b0, REG_STAT, 32'h0);
      chk("intf_flag", 32'h1, rdat[9]);
      chk("intf_code", 32'h9, rdat[19:16]);
      internal_fault <= 1'b0;
   endtask
   task automatic summarize;
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #1_000_000;
      bad_count++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_comm();
      t_diag();
      t_fault();
      summarize();
   end
endmodule
`default_nettype wire
